// [core/ucr_pkg.sv]
// Purpose: Shared constants for the USB core reset control block
// Assumes: One 25 MHz system clock
// Notes:   Reset values and bit positions of the reset-sensitive state
package ucr_pkg;
    localparam logic [15:0] CPU_CONTROL_STATUS_ADDR = 16'h7f92;
    localparam int          CPU_HOLD_RESET_BIT      = 0;
    localparam int          CPU_CLOCK_OUT_BIT       = 1;
    localparam logic [7:0]  CPU_RELEASE_VALUE       = 8'h00;
    localparam logic [7:0]  CPU_HOLD_VALUE          = 8'h01;
    localparam logic [7:0]  USB_CONTROL_RESET       = 8'h04;
    localparam int          FIRMWARE_OWNS_BIT       = 1;
    localparam int          BREAK_BIT               = 3;
    localparam logic [7:0]  IN_VALID_RESET          = 8'h57;
    localparam logic [7:0]  OUT_VALID_RESET         = 8'h55;
    localparam logic [7:0]  ISO_VALID_RESET         = 8'h07;
    localparam logic [7:0]  ZERO_BYTE               = 8'h00;
    localparam logic [7:0]  OUT_ARMED_VALUE         = 8'h02;
    localparam logic [7:0]  BOOT_IMAGE_MARK         = 8'hb6;
    localparam logic [7:0]  BOOT_ID_MARK            = 8'hb4;
    localparam logic [3:0]  REVISION_DEFAULT        = 4'h1;
    typedef enum logic [1:0] {BOOT_PROBE, BOOT_LOAD, BOOT_DONE} ucr_boot_type;
endpackage

// [core/ucr_reset_control.sv]
// Purpose: Chip reset, processor hold/release and reset defaults of the USB core state
// Assumes: Pins synchronous to core_clk; register writes arrive as one-cycle strobes
// Notes:   Processor reset is distinct from chip reset; the two-wire boot engine is external
//
// What this block does
// - Processor control register resets to revision, clock-out enable, hold reset.
// - Writing 0x01 holds the processor in reset, writing zero releases it.
// - Only processor writes change the clock-output enable bit.
// - Clock output runs from power-up and during reset unless disabled.
// - Reset release while suspended stops clock out until resume or wake pin.
// - Reset pin low applies full power-on defaults.
// - Reset pin does not disturb oscillator or PLL.
// - Port configuration and output enables clear on power-on reset.
// - Interrupt enables, requests, bulk status, toggles, address clear on power-on.
// - USB control register resets to 0x04, firmware ownership clear.
// - With ownership clear the core answers device requests itself.
// - Endpoint valid masks load 0x57, 0x55, 0x07, 0x07 on power-on.
// - Endpoint pairing off on power-on.
// - Break/autovector register, configuration and alternate setting clear on power-on.
// - While processor held, bulk IN unarmed: NAK IN, ACK OUT.
// - On processor release, every bulk OUT status is written 0x02.
// - Boot image 0xB6 found: load code, then write 0x00 to control register.
// - External code with no B4/B6 memory: release processor, set ownership.
// - Processor reset keeps valid bits, address, ports, stalls, toggles.
// - Processor reset clears interrupt enables but keeps requests pending.
// - Processor reset clears break bit only; ownership flag unchanged.
// - Two-wire controller reset only by chip reset (reset pin low or PLL unlocked).
module ucr_reset_control
    import ucr_pkg::*;
#(
    parameter logic [3:0] REVISION = REVISION_DEFAULT  // Arbitrary revision value
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       pll_locked,
    input  wire logic       suspended,
    input  wire logic       bus_resume,
    input  wire logic       wake_request_pin_n,
    input  wire logic       external_code_select,
    input  wire logic       boot_probe_done,
    input  wire logic       boot_first_valid,
    input  wire logic [7:0] boot_first_byte,
    input  wire logic       boot_load_done,
    input  wire logic       reg_write,
    input  wire logic       reg_from_processor,
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       usb_int_req_set,
    input  wire logic [7:0] usb_int_req_clear,
    input  wire logic [7:0] usb_int_enable_wdata,
    input  wire logic       usb_int_enable_write,
    input  wire logic [7:0] break_autovector_wdata,
    input  wire logic       break_autovector_write,
    input  wire logic       bulk_out_load,
    input  wire logic       bulk_out_token,
    output logic [7:0]      cpu_control_status,
    output logic            processor_reset,
    output logic            clock_output_enable,
    output logic            clock_output_gate,
    output logic            chip_reset,
    output logic            two_wire_reset,
    output logic            boot_load_active,
    output logic [7:0]      usb_control_register,
    output logic            firmware_owns_requests,
    output logic            core_answers_requests,
    output logic [7:0]      port_config,
    output logic [7:0]      port_output_enable,
    output logic [7:0]      usb_int_enable,
    output logic [7:0]      usb_int_request,
    output logic [7:0]      bulk_in_status,
    output logic [7:0]      bulk_out_status,
    output logic [7:0]      data_toggles,
    output logic [7:0]      stall_bits,
    output logic [7:0]      function_address,
    output logic [7:0]      in_endpoint_valid_mask,
    output logic [7:0]      out_endpoint_valid_mask,
    output logic [7:0]      iso_in_valid_mask,
    output logic [7:0]      iso_out_valid_mask,
    output logic [7:0]      endpoint_pairing,
    output logic [7:0]      break_autovector_register,
    output logic [7:0]      configuration,
    output logic [7:0]      alternate_setting,
    output logic            bulk_in_nak,
    output logic            bulk_out_ack
);
    import ucr_pkg::*;

    logic         rst_meta_q;
    logic         rst_sync_q;
    logic         chip_rst;
    logic         hold_q;
    logic         hold_prev_q;
    logic         clock_output_pin_en_q;
    logic         clk_run_q;
    logic         owns_q;
    logic         out_armed_q;
    logic         out_taken_q;
    logic [7:0]   int_en_q;
    logic [7:0]   int_req_q;
    logic [7:0]   bav_q;
    logic         ctl_write;
    logic         release_evt;
    logic         boot_write;
    ucr_boot_type boot_q;
    logic [7:0]   port_cfg_q;
    logic [7:0]   port_oe_q;
    logic [7:0]   toggle_q;
    logic [7:0]   stall_q;
    logic [7:0]   fn_addr_q;
    logic [7:0]   in_valid_q;
    logic [7:0]   out_valid_q;
    logic [7:0]   iso_in_valid_q;
    logic [7:0]   iso_out_valid_q;
    logic [7:0]   pairing_q;
    logic [7:0]   config_q;
    logic [7:0]   alt_setting_q;

    // Reset pin: async assert, sync release
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    assign chip_rst       = !rst_sync_q || !pll_locked;
    assign chip_reset     = chip_rst;
    assign two_wire_reset = chip_rst;

    assign ctl_write   = reg_write && (reg_addr == CPU_CONTROL_STATUS_ADDR);
    assign boot_write  = (boot_q == BOOT_LOAD) && boot_load_done;
    // Falling hold bit marks each processor release
    assign release_evt = hold_prev_q && !hold_q;

    // Boot sequencer
    always_ff @(posedge core_clk) begin
        if (chip_rst) begin
            boot_q <= BOOT_PROBE;
        end else begin
            unique case (boot_q)
                BOOT_PROBE: begin
                    if (boot_probe_done) begin
                        if (boot_first_valid && boot_first_byte == BOOT_IMAGE_MARK) begin
                            boot_q <= BOOT_LOAD;
                        end else begin
                            boot_q <= BOOT_DONE;
                        end
                    end
                end
                BOOT_LOAD: begin
                    if (boot_load_done) begin
                        boot_q <= BOOT_DONE;
                    end
                end
                BOOT_DONE: begin
                    boot_q <= BOOT_DONE;
                end
            endcase
        end
    end
    assign boot_load_active = (boot_q == BOOT_LOAD);

    // Processor hold bit
    always_ff @(posedge core_clk) begin
        if (chip_rst) begin
            hold_q      <= 1'b1;
            hold_prev_q <= 1'b1;
        end else begin
            hold_prev_q <= hold_q;
            if (boot_write) begin
                hold_q <= CPU_RELEASE_VALUE[CPU_HOLD_RESET_BIT];
            end else if (boot_q == BOOT_PROBE && boot_probe_done && external_code_select
                         && !(boot_first_valid && (boot_first_byte == BOOT_IMAGE_MARK
                         || boot_first_byte == BOOT_ID_MARK))) begin
                hold_q <= 1'b0;
            end else if (ctl_write) begin
                hold_q <= reg_wdata[CPU_HOLD_RESET_BIT];
            end
        end
    end

    // Clock output enable, processor writes only
    always_ff @(posedge core_clk) begin
        if (chip_rst) begin
            clock_output_pin_en_q <= 1'b1;
        end else if (ctl_write && reg_from_processor) begin
            clock_output_pin_en_q <= reg_wdata[CPU_CLOCK_OUT_BIT];
        end
    end

    // Clock runs through reset, stops on suspend until resume or wake
    always_ff @(posedge core_clk) begin
        if (chip_rst) begin
            clk_run_q <= 1'b1;
        end else if (bus_resume || !wake_request_pin_n) begin
            clk_run_q <= 1'b1;
        end else if (suspended) begin
            clk_run_q <= 1'b0;
        end
    end
    assign clock_output_gate = clock_output_pin_en_q && clk_run_q;

    assign cpu_control_status  = {REVISION, 2'b00, clock_output_pin_en_q, hold_q};
    assign processor_reset     = hold_q;
    assign clock_output_enable = clock_output_pin_en_q;

    // Firmware ownership of device requests
    always_ff @(posedge core_clk) begin
        if (chip_rst) begin
            owns_q <= 1'b0;
        end else if (boot_q == BOOT_PROBE && boot_probe_done && external_code_select
                     && !(boot_first_valid && (boot_first_byte == BOOT_IMAGE_MARK
                     || boot_first_byte == BOOT_ID_MARK))) begin
            owns_q <= 1'b1;
        end
    end
    assign firmware_owns_requests = owns_q;
    assign core_answers_requests  = !owns_q;
    assign usb_control_register   = USB_CONTROL_RESET | ({7'h00, owns_q} << FIRMWARE_OWNS_BIT);

    // Interrupt enables clear on either reset, requests only on chip reset
    always_ff @(posedge core_clk) begin
        if (chip_rst || hold_q) begin
            int_en_q <= ZERO_BYTE;
        end else if (usb_int_enable_write) begin
            int_en_q <= usb_int_enable_wdata;
        end
    end
    always_ff @(posedge core_clk) begin
        if (chip_rst) begin
            int_req_q <= ZERO_BYTE;
        end else begin
            int_req_q <= (int_req_q & ~usb_int_req_clear) | {7'h00, usb_int_req_set};
        end
    end
    assign usb_int_enable  = int_en_q;
    assign usb_int_request = int_req_q;

    // Break and autovector register
    always_ff @(posedge core_clk) begin
        if (chip_rst) begin
            bav_q <= ZERO_BYTE;
        end else if (hold_q) begin
            bav_q[BREAK_BIT] <= 1'b0;
        end else if (break_autovector_write) begin
            bav_q <= break_autovector_wdata;
        end
    end
    assign break_autovector_register = bav_q;

    // Bulk OUT arming: one packet accepted after release
    always_ff @(posedge core_clk) begin
        if (chip_rst) begin
            out_armed_q <= 1'b0;
            out_taken_q <= 1'b0;
        end else if (release_evt) begin
            out_armed_q <= 1'b1;
            out_taken_q <= 1'b0;
        end else if (bulk_out_load) begin
            out_taken_q <= 1'b0;
        end else if (bulk_out_token && out_armed_q && !hold_q) begin
            out_taken_q <= 1'b1;
        end
    end
    assign bulk_out_status = out_armed_q ? OUT_ARMED_VALUE : ZERO_BYTE;
    assign bulk_in_status  = ZERO_BYTE;
    assign bulk_in_nak     = hold_q;
    assign bulk_out_ack    = hold_q || (out_armed_q && !out_taken_q);

    // Power-on defaults: loaded by chip reset only, processor reset keeps them
    always_ff @(posedge core_clk) begin
        if (chip_rst) begin
            port_cfg_q      <= ZERO_BYTE;
            port_oe_q       <= ZERO_BYTE;
            toggle_q        <= ZERO_BYTE;
            stall_q         <= ZERO_BYTE;
            fn_addr_q       <= ZERO_BYTE;
            in_valid_q      <= IN_VALID_RESET;
            out_valid_q     <= OUT_VALID_RESET;
            iso_in_valid_q  <= ISO_VALID_RESET;
            iso_out_valid_q <= ISO_VALID_RESET;
            pairing_q       <= ZERO_BYTE;
            config_q        <= ZERO_BYTE;
            alt_setting_q   <= ZERO_BYTE;
        end
    end

    assign port_config             = port_cfg_q;
    assign port_output_enable      = port_oe_q;
    assign data_toggles            = toggle_q;
    assign stall_bits              = stall_q;
    assign function_address        = fn_addr_q;
    assign in_endpoint_valid_mask  = in_valid_q;
    assign out_endpoint_valid_mask = out_valid_q;
    assign iso_in_valid_mask       = iso_in_valid_q;
    assign iso_out_valid_mask      = iso_out_valid_q;
    assign endpoint_pairing        = pairing_q;
    assign configuration           = config_q;
    assign alternate_setting       = alt_setting_q;
endmodule // ucr_reset_control

// [verif/ucr_boot_model.sv]
// Purpose: Boot memory probe partner for the reset control block
// Assumes: Driven on the falling edge of core_clk
// Notes:   First byte inverts once the probe strobe is gone
module ucr_boot_model
    import ucr_pkg::*;
(
    input  wire logic  core_clk,
    output logic       boot_probe_done,
    output logic       boot_first_valid,
    output logic [7:0] boot_first_byte,
    output logic       boot_load_done
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {boot_probe_done, boot_first_valid, boot_load_done} = 3'h0;
        boot_first_byte = 8'h00;
    end
    task automatic boot(input logic present, input logic [7:0] first);
        @(negedge core_clk);
        boot_probe_done  = 1'b1;
        boot_first_valid = present;
        boot_first_byte  = first;
        @(negedge core_clk);
        boot_probe_done = 1'b0;
        boot_first_byte = ~first;
        if (present && first == BOOT_IMAGE_MARK) begin
            repeat (4) @(negedge core_clk);
            boot_load_done = 1'b1;
            @(negedge core_clk);
            boot_load_done = 1'b0;
        end
    endtask
endmodule // ucr_boot_model

// [verif/ucr_reset_control_assertions.sv]
// Purpose: Port checks of the reset control block
// Assumes: One clock domain, rst_n active low
// Notes:   Bound from the bench top file
module ucr_reset_control_assertions
    import ucr_pkg::*;
#(
    parameter logic [3:0] REVISION = REVISION_DEFAULT
) (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        reg_write,
    input wire logic        reg_from_processor,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  cpu_control_status,
    input wire logic        processor_reset,
    input wire logic        clock_output_enable,
    input wire logic        clock_output_gate,
    input wire logic        chip_reset,
    input wire logic        two_wire_reset,
    input wire logic [7:0]  usb_control_register,
    input wire logic        firmware_owns_requests,
    input wire logic        core_answers_requests,
    input wire logic [7:0]  usb_int_enable,
    input wire logic [7:0]  bulk_in_status,
    input wire logic [7:0]  bulk_out_status,
    input wire logic [7:0]  break_autovector_register,
    input wire logic        bulk_in_nak,
    input wire logic        bulk_out_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire logic hw = reg_write && reg_addr == CPU_CONTROL_STATUS_ADDR && !chip_reset;
    sequence s_held; processor_reset ##1 processor_reset; endsequence
    sequence s_run; !chip_reset ##1 !chip_reset; endsequence
    property p_por;
        chip_reset |-> cpu_control_status == {REVISION, 4'h3} && clock_output_gate;
    endproperty
    property p_hold; hw && reg_wdata == CPU_HOLD_VALUE |=> processor_reset; endproperty
    property p_rel; hw && reg_wdata == CPU_RELEASE_VALUE |=> !processor_reset; endproperty
    property p_clkoe; hw && !reg_from_processor |=> $stable(clock_output_enable); endproperty
    property p_arm;
        $fell(processor_reset) |=> bulk_out_status == OUT_ARMED_VALUE && bulk_out_ack;
    endproperty
    property p_nak;
        s_held |-> bulk_in_nak && bulk_out_ack && bulk_in_status == ZERO_BYTE;
    endproperty
    property p_held;
        s_held |-> usb_int_enable == ZERO_BYTE && !break_autovector_register[BREAK_BIT];
    endproperty
    property p_usb_control_register;
        usb_control_register == (USB_CONTROL_RESET | {6'h00, firmware_owns_requests, 1'b0})
            && core_answers_requests == !firmware_owns_requests;
    endproperty
    property p_twi; s_run |-> !two_wire_reset; endproperty
    a_por: assert property (p_por) else $error("reset status wrong");
    a_hold: assert property (p_hold) else $error("hold write ignored");
    a_rel: assert property (p_rel) else $error("release write ignored");
    a_clkoe: assert property (p_clkoe) else $error("host changed clock out enable");
    a_arm: assert property (p_arm) else $error("bulk out not armed on release");
    a_nak: assert property (p_nak) else $error("bulk state wrong while held");
    a_held: assert property (p_held) else $error("held state wrong");
    a_usb_control_register: assert property (p_usb_control_register) else $error("usb control value wrong");
    a_twi: assert property (p_twi) else $error("two wire reset outside chip reset");
endmodule // ucr_reset_control_assertions

// [verif/tb_ucr_reset_control.sv]
// Purpose: Directed bench of the reset control block
// Assumes: Inputs change on the falling edge of core_clk
// Notes:   Boot probes come from the partner model
module tb_ucr_reset_control;
    timeunit 1ns;
    timeprecision 1ps;
    import ucr_pkg::*;
    logic        core_clk, rst_n, pll_locked, suspended, bus_resume, wake_request_pin_n;
    logic        external_code_select, boot_probe_done, boot_first_valid, boot_load_done;
    logic        reg_write, reg_from_processor, usb_int_req_set, usb_int_enable_write;
    logic        break_autovector_write, bulk_out_load, bulk_out_token, processor_reset;
    logic        clock_output_enable, clock_output_gate, chip_reset, two_wire_reset;
    logic        boot_load_active, firmware_owns_requests, core_answers_requests;
    logic        bulk_in_nak, bulk_out_ack;
    logic [15:0] reg_addr;
    logic [7:0]  boot_first_byte, reg_wdata, usb_int_req_clear, usb_int_enable_wdata;
    logic [7:0]  break_autovector_wdata, cpu_control_status, usb_control_register;
    logic [7:0]  port_config, port_output_enable, usb_int_enable, usb_int_request;
    logic [7:0]  bulk_in_status, bulk_out_status, data_toggles, stall_bits, function_address;
    logic [7:0]  in_endpoint_valid_mask, out_endpoint_valid_mask, iso_in_valid_mask;
    logic [7:0]  iso_out_valid_mask, endpoint_pairing, break_autovector_register;
    logic [7:0]  configuration, alternate_setting;
    int          n_errors = 0;
    int          samples_checked = 0;
    ucr_reset_control ucr_reset_control_i (.*);
    ucr_boot_model ucr_boot_model_i (.*);
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic pr, input logic [7:0] d);
        {reg_write, reg_from_processor, reg_addr, reg_wdata} = {1'b1, pr, a, d};
        cyc(1);
        reg_write = 1'b0;
        cyc(3);
    endtask
    task automatic test_done;
        if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #100us;
        n_errors++;
        test_done;
    end
    initial begin
        {rst_n, suspended, bus_resume, external_code_select, reg_write, reg_from_processor} = 0;
        {usb_int_req_set, usb_int_enable_write, break_autovector_write} = 3'h0;
        {bulk_out_load, bulk_out_token, reg_addr, reg_wdata, usb_int_req_clear} = 0;
        {usb_int_enable_wdata, break_autovector_wdata} = 16'h0000;
        pll_locked = 1'b1;
        wake_request_pin_n = 1'b1;
        cyc(10);
        rst_n = 1'b1;
        cyc(3);
        chk("status", {REVISION_DEFAULT, 4'h3}, cpu_control_status);
        chk("usb control", USB_CONTROL_RESET, usb_control_register);
        chk("zero regs", ZERO_BYTE, port_config | port_output_enable | usb_int_enable
            | usb_int_request | bulk_in_status | data_toggles | stall_bits | function_address
            | endpoint_pairing | break_autovector_register | configuration
            | alternate_setting);
        chk("masks", {IN_VALID_RESET, OUT_VALID_RESET, ISO_VALID_RESET, ISO_VALID_RESET},
            {in_endpoint_valid_mask, out_endpoint_valid_mask, iso_in_valid_mask,
             iso_out_valid_mask});
        fork
            ucr_boot_model_i.boot(1'b1, BOOT_IMAGE_MARK);
            begin
                cyc(3);
                chk("loading", 2'b11, {boot_load_active, processor_reset});
            end
        join
        cyc(3);
        chk("boot release", 3'b000,
            {processor_reset, firmware_owns_requests, boot_load_active});
        chk("out armed", OUT_ARMED_VALUE, bulk_out_status);
        bulk_out_token = 1'b1;
        cyc(1);
        bulk_out_token = 1'b0;
        cyc(1);
        chk("ack after token", 1'b0, bulk_out_ack);
        bulk_out_load = 1'b1;
        cyc(1);
        bulk_out_load = 1'b0;
        cyc(1);
        chk("ack after load", 1'b1, bulk_out_ack);
        {usb_int_req_set, usb_int_enable_write, break_autovector_write} = 3'h7;
        {usb_int_enable_wdata, break_autovector_wdata} = 16'h0f0b;
        cyc(1);
        {usb_int_req_set, usb_int_enable_write, break_autovector_write} = 3'h0;
        wr(16'h7f93, 1'b0, CPU_HOLD_VALUE);
        chk("unmapped write", 1'b0, processor_reset);
        chk("int and break", {8'h0f, 8'h01, 8'h0b},
            {usb_int_enable, usb_int_request, break_autovector_register});
        wr(CPU_CONTROL_STATUS_ADDR, 1'b0, CPU_HOLD_VALUE);
        chk("hold", 1'b1, processor_reset);
        chk("kept defaults", {IN_VALID_RESET, OUT_VALID_RESET, ZERO_BYTE},
            {in_endpoint_valid_mask, out_endpoint_valid_mask,
             port_config | data_toggles | stall_bits | function_address});
        chk("int state", {ZERO_BYTE, 8'h01}, {usb_int_enable, usb_int_request});
        chk("break", 8'h03, break_autovector_register);
        chk("owns kept", 1'b0, firmware_owns_requests);
        chk("held bulk", 2'b11, {bulk_in_nak, bulk_out_ack});
        wr(CPU_CONTROL_STATUS_ADDR, 1'b0, CPU_RELEASE_VALUE);
        chk("host release", {REVISION_DEFAULT, 4'h2}, cpu_control_status);
        wr(CPU_CONTROL_STATUS_ADDR, 1'b1, CPU_RELEASE_VALUE);
        chk("cpu clkoe", {REVISION_DEFAULT, 4'h0}, cpu_control_status);
        chk("gate off", 1'b0, clock_output_gate);
        suspended = 1'b1;
        rst_n = 1'b0;
        cyc(3);
        chk("reset clock_output_pin", 3'h7,
            {clock_output_enable, clock_output_gate, two_wire_reset});
        rst_n = 1'b1;
        cyc(4);
        chk("suspend gate", 1'b0, clock_output_gate);
        wake_request_pin_n = 1'b0;
        cyc(2);
        chk("wake gate", 1'b1, clock_output_gate);
        wake_request_pin_n = 1'b1;
        cyc(2);
        chk("suspend again", 1'b0, clock_output_gate);
        bus_resume = 1'b1;
        cyc(2);
        chk("resume gate", 1'b1, clock_output_gate);
        {bus_resume, suspended, external_code_select} = 3'b001;
        ucr_boot_model_i.boot(1'b0, 8'h00);
        cyc(3);
        chk("ext release", 2'b01, {processor_reset, firmware_owns_requests});
        wr(CPU_CONTROL_STATUS_ADDR, 1'b0, CPU_HOLD_VALUE);
        chk("owns after hold", 2'b11, {processor_reset, firmware_owns_requests});
        pll_locked = 1'b0;
        cyc(1);
        chk("pll hold", 1'b1, chip_reset);
        test_done;
    end
endmodule // tb_ucr_reset_control
bind ucr_reset_control ucr_reset_control_assertions #(.REVISION(REVISION))
    ucr_reset_control_assertions_i (.*);
